// *** src/lbm_pkg.sv ***
// Package of constants for the local bus peripheral interrupt mask block
// ==========================================================================
// Function
// - A set channel A message-end mask bit makes the block ignore channel A message-end events.
// - A set channel A pool-full mask bit makes the block ignore channel A pool-full events.
// - A set channel B message-end mask bit makes the block ignore channel B message-end events.
// - Interrupt mode on channel A addresses the peripheral with offset A and FIFO pointer A.
// - Interrupt mode on channel B addresses the peripheral with offset B and FIFO pointer B.
// - DMA transfers on channel A use offset C and FIFO pointer C.
// - DMA transfers on channel B use offset D and FIFO pointer D.
// - A set channel B mask-all bit makes the block ignore every channel B event.
// - A set channel B transmit-ready mask bit makes the block ignore channel B transmit-ready events.
package lbm_pkg;
	// ======================================================================
	// Register map
	localparam logic [3:0] LBM_ADDR_MASK = 4'h0; // Peripheral mask register
	localparam logic [3:0] LBM_ADDR_MODE = 4'h1; // Transfer mode select
	localparam logic [3:0] LBM_ADDR_PTRA = 4'h2; // Offset/FIFO pointer set A
	localparam logic [3:0] LBM_ADDR_PTRB = 4'h3;
	localparam logic [3:0] LBM_ADDR_PTRC = 4'h4;
	localparam logic [3:0] LBM_ADDR_PTRD = 4'h5;
	localparam logic [3:0] LBM_ADDR_STAT = 4'h6; // Sticky event status, write one to clear
	localparam logic [3:0] LBM_ADDR_IEN = 4'h7; // Interrupt enable mask
	// ======================================================================
	// Mask register field positions
	localparam int LBM_B_PF_A = 0;
	localparam int LBM_B_ME_A = 1;
	localparam int LBM_B_TX_A = 2;
	localparam int LBM_B_ALL_A = 3;
	localparam int LBM_B_PF_B = 4;
	localparam int LBM_B_ME_B = 5;
	localparam int LBM_B_TX_B = 6;
	localparam int LBM_B_ALL_B = 7;
	localparam logic [7:0] LBM_MASK_RST = 8'h00;
	localparam logic [1:0] LBM_MODE_RST = 2'h0;
	localparam logic [15:0] LBM_PTR_RST = 16'h0000;
	localparam logic [31:0] LBM_ZERO = 32'h00000000;
	// Status bits: per-channel passed events, layout as the mask's low 3 bits
	localparam int LBM_NSTAT = 6;
	// Pointer word: offset in bits 7:0, FIFO pointer in bits 15:8
	localparam int LBM_PTR_OFS_LO = 0;
	localparam int LBM_PTR_FIFO_LO = 8;
	typedef enum logic [1:0] {
		LBM_MODE_INT_A = 2'b00,
		LBM_MODE_INT_B = 2'b01,
		LBM_MODE_DMA_A = 2'b10,
		LBM_MODE_DMA_B = 2'b11
	} lbm_mode_e;
endpackage : lbm_pkg

// *** src/lbm_chan_filter.sv ***
// Per-channel interrupt filter for one peripheral channel
`timescale 1ns/10ps
`default_nettype none
module lbm_chan_filter (
	input wire logic mask_all, // Hide every event of this channel
	input wire logic tx_mask, // Hide transmit-pool-ready
	input wire logic me_mask, // Hide receive-message-end
	input wire logic pf_mask, // Hide receive-pool-full
	input wire logic [2:0] ev_raw, // Raw events: 2 tx ready, 1 msg end, 0 pool full
	output logic [2:0] ev_kept // Events that survive the masks
);
	// Mask-all overrides the individual bits
	assign ev_kept[2] = ev_raw[2] & ~tx_mask & ~mask_all;
	assign ev_kept[1] = ev_raw[1] & ~me_mask & ~mask_all;
	assign ev_kept[0] = ev_raw[0] & ~pf_mask & ~mask_all;
endmodule : lbm_chan_filter
`default_nettype wire

// *** src/lbm_ptr_sel.sv ***
// Transfer mode pointer selector
`timescale 1ns/10ps
`default_nettype none
module lbm_ptr_sel (
	input wire lbm_pkg::lbm_mode_e mode, // Selected transfer mode
	input wire logic [15:0] ptr_a, // Pointer set A
	input wire logic [15:0] ptr_b, // Pointer set B
	input wire logic [15:0] ptr_c, // Pointer set C
	input wire logic [15:0] ptr_d, // Pointer set D
	output logic [15:0] ptr_sel // Pointer set in use
);
	import lbm_pkg::*;
	// One pointer pair per mode
	always_comb begin
		case (mode)
			LBM_MODE_INT_A: ptr_sel = ptr_a;
			LBM_MODE_INT_B: ptr_sel = ptr_b;
			LBM_MODE_DMA_A: ptr_sel = ptr_c;
			LBM_MODE_DMA_B: ptr_sel = ptr_d;
			default: ptr_sel = ptr_a;
		endcase
	end
endmodule : lbm_ptr_sel
`default_nettype wire

// *** src/lbm_top.sv ***
// Interrupt masking and pointer selection for the two-channel bus peripheral
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module lbm_top (
	input wire logic ref_clk, // System clock, 200 MHz
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic clk_en, // Freezes all state while low
	input wire logic [3:0] reg_addr, // Register index
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic [2:0] periph_irq_a, // Channel A events: 2 tx, 1 msg end, 0 pool full
	input wire logic [2:0] periph_irq_b, // Channel B events, same layout
	output logic [2:0] irq_pass_a, // Registered surviving A events
	output logic [2:0] irq_pass_b, // Registered surviving B events
	output logic [7:0] ptr_offset, // Offset pointer in use
	output logic [7:0] ptr_fifo, // FIFO pointer in use
	output lbm_pkg::lbm_mode_e mode_cur, // Current transfer mode
	output logic irq // Level interrupt
);
	import lbm_pkg::*;

	// ======================================================================
	// Register state
	logic [7:0] mask_reg;
	lbm_mode_e mode_reg;
	logic [15:0] ptr_a_reg, ptr_b_reg, ptr_c_reg, ptr_d_reg;
	logic [LBM_NSTAT-1:0] stat_reg;
	logic [LBM_NSTAT-1:0] ien_reg;
	logic [2:0] filt_a, filt_b;
	logic [15:0] ptr_sel;
	logic wr_mask, wr_mode, wr_stat, wr_ien;

	assign wr_mask = reg_wr & (reg_addr == LBM_ADDR_MASK);
	assign wr_mode = reg_wr & (reg_addr == LBM_ADDR_MODE);
	assign wr_stat = reg_wr & (reg_addr == LBM_ADDR_STAT);
	assign wr_ien = reg_wr & (reg_addr == LBM_ADDR_IEN);

	// Mask register; its value is software's to choose per peripheral
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_reg <= LBM_MASK_RST;
		end else if (clk_en && wr_mask) begin
			mask_reg <= reg_wdata[7:0];
		end
	end

	// Transfer mode
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg <= lbm_mode_e'(LBM_MODE_RST);
		end else if (clk_en && wr_mode) begin
			mode_reg <= lbm_mode_e'(reg_wdata[1:0]);
		end
	end

	// Pointer sets, one per mode
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_a_reg <= LBM_PTR_RST;
			ptr_b_reg <= LBM_PTR_RST;
			ptr_c_reg <= LBM_PTR_RST;
			ptr_d_reg <= LBM_PTR_RST;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == LBM_ADDR_PTRA) ptr_a_reg <= reg_wdata[15:0];
			if (reg_addr == LBM_ADDR_PTRB) ptr_b_reg <= reg_wdata[15:0];
			if (reg_addr == LBM_ADDR_PTRC) ptr_c_reg <= reg_wdata[15:0];
			if (reg_addr == LBM_ADDR_PTRD) ptr_d_reg <= reg_wdata[15:0];
		end
	end

	// ======================================================================
	// Channel filters
	lbm_chan_filter u_filt_a (
		.mask_all(mask_reg[LBM_B_ALL_A]),
		.tx_mask(mask_reg[LBM_B_TX_A]),
		.me_mask(mask_reg[LBM_B_ME_A]),
		.pf_mask(mask_reg[LBM_B_PF_A]),
		.ev_raw(periph_irq_a),
		.ev_kept(filt_a)
	);
	lbm_chan_filter u_filt_b (
		.mask_all(mask_reg[LBM_B_ALL_B]),
		.tx_mask(mask_reg[LBM_B_TX_B]),
		.me_mask(mask_reg[LBM_B_ME_B]),
		.pf_mask(mask_reg[LBM_B_PF_B]),
		.ev_raw(periph_irq_b),
		.ev_kept(filt_b)
	);

	lbm_ptr_sel u_sel (
		.mode(mode_reg),
		.ptr_a(ptr_a_reg),
		.ptr_b(ptr_b_reg),
		.ptr_c(ptr_c_reg),
		.ptr_d(ptr_d_reg),
		.ptr_sel(ptr_sel)
	);

	// Sticky status: a new event wins over a write-one clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < LBM_NSTAT; gi++) begin : g_stat
			logic ev;
			assign ev = (gi < 3) ? filt_a[gi % 3] : filt_b[gi % 3];
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					stat_reg[gi] <= 1'b0;
				end else if (clk_en) begin
					stat_reg[gi] <= ev | (stat_reg[gi] & ~(wr_stat & reg_wdata[gi]));
				end
			end
		end
	endgenerate

	// Interrupt enable mask
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ien_reg <= '0;
		end else if (clk_en && wr_ien) begin
			ien_reg <= reg_wdata[LBM_NSTAT-1:0];
		end
	end

	// ======================================================================
	// Registered outputs; pointer and events lag their cause by one cycle
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_pass_a <= 3'h0;
			irq_pass_b <= 3'h0;
			ptr_offset <= 8'h00;
			ptr_fifo <= 8'h00;
			mode_cur <= lbm_mode_e'(LBM_MODE_RST);
			irq <= 1'b0;
		end else if (clk_en) begin
			irq_pass_a <= filt_a;
			irq_pass_b <= filt_b;
			ptr_offset <= ptr_sel[LBM_PTR_OFS_LO +: 8];
			ptr_fifo <= ptr_sel[LBM_PTR_FIFO_LO +: 8];
			mode_cur <= mode_reg;
			irq <= |(stat_reg & ien_reg);
		end
	end

	// Read port: data the cycle after the strobe, unmapped reads zero
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= LBM_ZERO;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					LBM_ADDR_MASK: reg_rdata <= {24'h000000, mask_reg};
					LBM_ADDR_MODE: reg_rdata <= {30'h0, mode_reg};
					LBM_ADDR_PTRA: reg_rdata <= {16'h0000, ptr_a_reg};
					LBM_ADDR_PTRB: reg_rdata <= {16'h0000, ptr_b_reg};
					LBM_ADDR_PTRC: reg_rdata <= {16'h0000, ptr_c_reg};
					LBM_ADDR_PTRD: reg_rdata <= {16'h0000, ptr_d_reg};
					LBM_ADDR_STAT: reg_rdata <= {26'h0, stat_reg};
					LBM_ADDR_IEN: reg_rdata <= {26'h0, ien_reg};
					default: reg_rdata <= LBM_ZERO;
				endcase
			end else begin
				reg_rdata <= LBM_ZERO;
			end
		end
	end
endmodule : lbm_top
`default_nettype wire

// *** bench/lbm_periph_model.sv ***
// Model of the external peripheral's event lines
`timescale 1ns/10ps
`default_nettype none
module lbm_periph_model (
	input wire logic ref_clk, // System clock
	input wire logic [2:0] ev_a, // Requested channel A events
	input wire logic [2:0] ev_b, // Requested channel B events
	output logic [2:0] irq_a, // Channel A event lines
	output logic [2:0] irq_b // Channel B event lines
);
	// Events leave on a clock edge, as a synchronous peripheral's would
	always_ff @(posedge ref_clk) begin
		irq_a <= ev_a;
		irq_b <= ev_b;
	end
endmodule : lbm_periph_model
`default_nettype wire

// *** bench/lbm_properties.sv ***
// Checker for the interrupt mask and pointer selection block
`timescale 1ns/10ps
`default_nettype none
module lbm_checker (
	input wire logic ref_clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic clk_en, // Enable
	input wire logic [3:0] reg_addr, // Index
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic [2:0] periph_irq_a, // A events
	input wire logic [2:0] periph_irq_b, // B events
	input wire logic [2:0] irq_pass_a, // A passed
	input wire logic [2:0] irq_pass_b, // B passed
	input wire logic [7:0] ptr_offset, // Offset in use
	input wire logic [7:0] ptr_fifo // FIFO pointer in use
);
	import lbm_pkg::*;
	logic [7:0] m_reg;
	logic [1:0] md_reg;
	logic [15:0] p_reg [4];
	logic [2:0] ea;
	logic [15:0] ps;
	// ====
	// Shadow state: the checker sees only ports, so it follows the writes
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			m_reg <= LBM_MASK_RST;
			md_reg <= LBM_MODE_RST;
			p_reg <= '{default: LBM_PTR_RST};
		end else if (clk_en && reg_wr) begin
			if (reg_addr == LBM_ADDR_MASK) m_reg <= reg_wdata[7:0];
			if (reg_addr == LBM_ADDR_MODE) md_reg <= reg_wdata[1:0];
			if (reg_addr >= LBM_ADDR_PTRA && reg_addr <= LBM_ADDR_PTRD) begin
				p_reg[2'(reg_addr - LBM_ADDR_PTRA)] <= reg_wdata[15:0];
			end
		end
	end
	// Expected survivors and pointer set
	assign ea = periph_irq_a & ~({3{m_reg[3]}} | m_reg[2:0]);
	assign ps = p_reg[md_reg];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ====
	// Assertions
	a_me_a_hidden: assert property (clk_en && m_reg[1]
		|=> !irq_pass_a[1]) else $error("A msg end passed while masked");
	a_pf_a_hidden: assert property (clk_en && m_reg[0]
		|=> !irq_pass_a[0]) else $error("A pool full passed while masked");
	a_me_b_hidden: assert property (clk_en && m_reg[5]
		|=> !irq_pass_b[1]) else $error("B msg end passed while masked");
	a_pass_a_exact: assert property (clk_en
		|=> irq_pass_a == $past(ea)) else $error("A passed events wrong");
	a_all_b_hidden: assert property (clk_en && m_reg[7]
		|=> irq_pass_b == 3'h0) else $error("B event passed under mask all");
	a_tx_b_hidden: assert property (clk_en && m_reg[6]
		|=> !irq_pass_b[2]) else $error("B tx ready passed while masked");
	a_ptr_int: assert property (clk_en && !md_reg[1]
		|=> {ptr_fifo, ptr_offset} == $past(ps)) else $error("Interrupt mode pointer wrong");
	a_ptr_dma: assert property (clk_en && md_reg[1]
		|=> {ptr_fifo, ptr_offset} == $past(ps)) else $error("DMA mode pointer wrong");
	c_all_a: cover property (m_reg[3] && periph_irq_a != 3'h0);
	c_dma_b: cover property (md_reg == LBM_MODE_DMA_B);
	c_pass_b: cover property (irq_pass_b == 3'h7);
endmodule : lbm_checker
bind lbm_top lbm_checker u_chk (.ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
	.periph_irq_a, .periph_irq_b, .irq_pass_a, .irq_pass_b, .ptr_offset, .ptr_fifo);
`default_nettype wire

// *** bench/lbm_top_tb.sv ***
// Testbench for the interrupt mask and pointer selection block
`timescale 1ns/10ps
`default_nettype none
module lbm_top_tb;
	import lbm_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst, clk_en, reg_wr, reg_rd, irq;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0] ev_a, ev_b, periph_irq_a, periph_irq_b, irq_pass_a, irq_pass_b;
	logic [7:0] ptr_offset, ptr_fifo, m;
	lbm_mode_e mode_cur;
	int n_fail = 0;
	int compares = 0;
	always #2.5 ref_clk = ~ref_clk;
	lbm_top dut (.ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .periph_irq_a, .periph_irq_b, .irq_pass_a, .irq_pass_b, .ptr_offset,
		.ptr_fifo, .mode_cur, .irq);
	lbm_periph_model peer (.ref_clk, .ev_a, .ev_b, .irq_a(periph_irq_a), .irq_b(periph_irq_b));
	// ====
	// Bus tasks and comparison
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	// Survivors of all-ones events under one channel's mask nibble
	function automatic logic [2:0] keep(input logic [3:0] mk);
		return ~({3{mk[3]}} | mk[2:0]);
	endfunction : keep
	task wait3;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : wait3
	task wrap_up;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// ====
	// Main sequence: fixed latencies only, so no wait can hang
	initial begin
		{sys_rst, clk_en, reg_wr, reg_rd, reg_addr, reg_wdata, ev_a, ev_b} = '0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(LBM_ADDR_MASK, 32'h0);
		rd(4'h9, 32'h0);
		ev_a <= 3'h7;
		ev_b <= 3'h7;
		for (int i = 0; i < 9; i++) begin
			m = 8'h01 << i;
			wr(LBM_ADDR_MASK, {24'h0, m});
			wait3();
			chk(irq_pass_a, keep(m[3:0]));
			chk(irq_pass_b, keep(m[7:4]));
		end
		for (int i = 0; i < 4; i++) wr(LBM_ADDR_PTRA + 4'(i), 32'hC050 + 32'h0101 * i);
		for (int i = 0; i < 4; i++) begin
			wr(LBM_ADDR_MODE, i);
			wait3();
			chk({ptr_fifo, ptr_offset}, 32'hC050 + 32'h0101 * i);
			chk(mode_cur, i);
		end
		// Frozen clock enable must ignore a write
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(LBM_ADDR_MASK, 32'hFF);
		clk_en <= 1'b1;
		// An unmapped write must leave the mask register alone
		wr(4'h9, 32'hFF);
		rd(LBM_ADDR_MASK, 32'h0);
		rd(LBM_ADDR_STAT, 32'h3F);
		chk(irq, 1'b0);
		wr(LBM_ADDR_IEN, 32'h01);
		ev_a <= 3'h0;
		ev_b <= 3'h0;
		wait3();
		chk(irq, 1'b1);
		wr(LBM_ADDR_STAT, 32'h3E);
		wait3();
		chk(irq, 1'b1);
		wr(LBM_ADDR_STAT, 32'h01);
		wait3();
		chk(irq, 1'b0);
		rd(LBM_ADDR_STAT, 32'h0);
		// A clear that meets a live event loses to it
		ev_a <= 3'h1;
		wait3();
		wr(LBM_ADDR_STAT, 32'h01);
		rd(LBM_ADDR_STAT, 32'h01);
		wrap_up();
	end
endmodule : lbm_top_tb
`default_nettype wire
